// File: hdl/odp_pkg.sv
package odp_pkg;

	// Slave address: fixed upper five bits, then two strap bits, then R/W
	localparam logic [4:0] ADDR_FIXED      = 5'h0B;
	localparam logic [1:0] ADDR_LOW_FIXED  = 2'h3;

	// Instruction byte field positions
	localparam int INS_CHAN_BIT = 7;
	localparam int INS_SD_BIT   = 6;
	localparam int INS_PROG_BIT = 5;
	localparam int INS_ZERO_BIT = 4;
	localparam int INS_OW_BIT   = 3;

	// Reset and preset values
	localparam logic [7:0] WIPER_MIDSCALE = 8'h80;

	// Fuse validation status codes
	localparam logic [1:0] STAT_READY = 2'h0;
	localparam logic [1:0] STAT_FATAL = 2'h2;
	localparam logic [1:0] STAT_DONE  = 2'h3;

	// Timing
	localparam int CLK_HZ       = 40_000_000;
	localparam int PROG_TIME_MS = 400;
	localparam int PROG_CYCLES  = PROG_TIME_MS * (CLK_HZ / 1000);
	localparam int PROG_CNT_W   = 24;

	typedef enum logic [2:0] {
		ST_IDLE     = 3'h0,
		ST_ADDR     = 3'h1,
		ST_ADDR_ACK = 3'h2,
		ST_RX       = 3'h3,
		ST_RX_ACK   = 3'h4,
		ST_TX       = 3'h5,
		ST_TX_ACK   = 3'h6
	} odp_state_t;

	// One potentiometer channel as seen by the analog switch matrix
	typedef struct packed {
		logic       a_open;
		logic       w_to_b;
		logic [7:0] code;
	} odp_chan_t;

	// Fuse burn request towards the fuse array
	typedef struct packed {
		logic       burn;
		logic       chan;
		logic [7:0] code;
	} odp_burn_t;

endpackage

// File: hdl/odp_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module odp_pin_sync (
	// Clock and reset
	input  wire logic       sys_clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic       ce_i,
	// Raw pins
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	input  wire logic [1:0] strap_i,
	// Synchronised levels and events
	output logic            sda_o,
	output logic [1:0]      strap_o,
	output logic            start_o,
	output logic            stop_o,
	output logic            scl_rise_o,
	output logic            scl_fall_o
);

	logic [1:0] scl_meta_q;
	logic [1:0] sda_meta_q;
	logic [1:0] strap_meta_q;
	logic [1:0] strap_q;
	logic       scl_q;
	logic       sda_q;
	logic       scl_prev_q;
	logic       sda_prev_q;

	// Two stages before any logic; the bus idles high
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			scl_meta_q   <= 2'h3;
			sda_meta_q   <= 2'h3;
			strap_meta_q <= 2'h0;
			strap_q      <= 2'h0;
			scl_prev_q   <= 1'h1;
			sda_prev_q   <= 1'h1;
		end else if (ce_i) begin
			scl_meta_q   <= {scl_meta_q[0], scl_i};
			sda_meta_q   <= {sda_meta_q[0], sda_i};
			strap_meta_q <= strap_i;
			strap_q      <= strap_meta_q;
			scl_prev_q   <= scl_q;
			sda_prev_q   <= sda_q;
		end
	end

	assign scl_q   = scl_meta_q[1];
	assign sda_q   = sda_meta_q[1];
	assign sda_o   = sda_q;
	assign strap_o = strap_q;

	assign start_o    = ce_i & scl_q & scl_prev_q & sda_prev_q & ~sda_q;
	assign stop_o     = ce_i & scl_q & scl_prev_q & ~sda_prev_q & sda_q;
	assign scl_rise_o = ce_i & scl_q & ~scl_prev_q;
	assign scl_fall_o = ce_i & ~scl_q & scl_prev_q;

endmodule

`default_nettype wire

// File: hdl/odp_fuse_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module odp_fuse_ctrl
	import odp_pkg::*;
#(
	parameter int PROG_LEN = PROG_CYCLES
) (
	// Clock and reset
	input  wire logic       sys_clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic       ce_i,
	// Fuse array state
	input  wire logic       fuse_blown_i,
	input  wire logic       fuse_ok_i,
	// Burn request from the command logic
	input  wire logic       prog_req_i,
	input  wire logic       prog_chan_i,
	input  wire logic [7:0] prog_code_i,
	// Results
	output odp_burn_t       burn_o,
	output logic [1:0]      status_o
);

	logic                  init_q;
	logic [PROG_CNT_W-1:0] cnt_q;

	// Status is captured from the array once reset has gone
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			init_q   <= 1'h1;
			status_o <= STAT_READY;
		end else if (ce_i) begin
			init_q <= 1'h0;
			if (init_q) begin
				status_o <= fuse_blown_i ? STAT_DONE : STAT_READY;
			end else if (burn_o.burn && cnt_q == PROG_CNT_W'(1)) begin
				status_o <= fuse_ok_i ? STAT_DONE : STAT_FATAL;
			end
		end
	end

	// One attempt only: any status other than ready refuses the request
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			burn_o <= '0;
			cnt_q  <= '0;
		end else if (ce_i) begin
			if (burn_o.burn) begin
				cnt_q <= cnt_q - PROG_CNT_W'(1);
				if (cnt_q == PROG_CNT_W'(1)) begin
					burn_o.burn <= 1'h0;
				end
			end else if (prog_req_i && !init_q && status_o == STAT_READY) begin
				burn_o.burn <= 1'h1;
				burn_o.chan <= prog_chan_i;
				burn_o.code <= prog_code_i;
				cnt_q       <= PROG_CNT_W'(PROG_LEN);
			end
		end
	end

endmodule

`default_nettype wire

// File: hdl/odp_cmd_slave.sv
// Functional notes
// - Shutdown opens terminal A of the selected channel and ties its wiper to terminal B.
// - Shutdown never alters the stored wiper code, which reappears when shutdown is released.
// - A program bit of one burns the selected channel's current code into the fuses.
// - With the override bit set, new codes are accepted and applied even after the fuses are blown.
// - After reset each wiper starts at midscale, or at the fuse code when the fuses are blown.
// - The wiper code is one byte, most significant bit first.
// - Validation status reads 00 while the fuses are unprogrammed.
// - Validation status reads 10 when a burn left fuses unblown.
// - Validation status reads 11 after a good burn, and no more burns are possible.
// - The channel select bit picks the wiper latch used by commands and readback.
// - Channel select low addresses channel one, high addresses channel two.
// - Clearing the override bit restores the code held before the override began.
// - A read returns the code of the channel last selected by a write instruction.
`timescale 1ns/1ps
`default_nettype none

module odp_cmd_slave
	import odp_pkg::*;
#(
	parameter bit STRAPPED = 1'h1,
	parameter int PROG_LEN = PROG_CYCLES
) (
	// Clock, reset, enable
	input  wire logic            sys_clk_i,
	input  wire logic            sys_rst_i,
	input  wire logic            ce_i,
	// Serial bus pins
	input  wire logic            scl_i,
	input  wire logic            sda_i,
	output logic                 sda_o,
	output logic                 sda_oe_o,
	// Address straps
	input  wire logic            strap_pin_hi_i,
	input  wire logic            strap_pin_lo_i,
	// Fuse array
	input  wire logic            fuse_blown_i,
	input  wire logic [1:0][7:0] fuse_code_i,
	input  wire logic            fuse_ok_i,
	output odp_burn_t            fuse_burn_o,
	// Analog channel controls
	output odp_chan_t            chan1_o,
	output odp_chan_t            chan2_o,
	// Status
	output logic [1:0]           fuse_status_o
);

	////////////////////////////////////////////////////////////////////////////////
	// Elaboration checks

	if (PROG_LEN < 1 || PROG_LEN >= (1 << PROG_CNT_W)) begin : g_bad_len
		$error("PROG_LEN out of range");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin front end and fuse control

	logic       sda_s;
	logic [1:0] strap_s;
	logic       start_p;
	logic       stop_p;
	logic       rise_p;
	logic       fall_p;
	logic       prog_req;
	logic       prog_chan;
	logic [7:0] prog_code;
	logic       chan_sel_q;
	odp_burn_t  burn_w;
	logic [1:0] status_w;

	odp_pin_sync i_odp_pin_sync (
		.sys_clk_i  (sys_clk_i),
		.sys_rst_i  (sys_rst_i),
		.ce_i       (ce_i),
		.scl_i      (scl_i),
		.sda_i      (sda_i),
		.strap_i    ({strap_pin_hi_i, strap_pin_lo_i}),
		.sda_o      (sda_s),
		.strap_o    (strap_s),
		.start_o    (start_p),
		.stop_o     (stop_p),
		.scl_rise_o (rise_p),
		.scl_fall_o (fall_p)
	);

	odp_fuse_ctrl #(
		.PROG_LEN (PROG_LEN)
	) i_odp_fuse_ctrl (
		.sys_clk_i   (sys_clk_i),
		.sys_rst_i   (sys_rst_i),
		.ce_i        (ce_i),
		.fuse_blown_i(fuse_blown_i),
		.fuse_ok_i   (fuse_ok_i),
		.prog_req_i  (prog_req),
		.prog_chan_i (prog_chan),
		.prog_code_i (prog_code),
		.burn_o      (burn_w),
		.status_o    (status_w)
	);

	assign fuse_burn_o   = burn_w;
	assign fuse_status_o = status_w;

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic addr_match(input logic [6:0] addr, input logic [1:0] strap);
		logic [1:0] low;
		low = STRAPPED ? strap : ADDR_LOW_FIXED;
		return addr == {ADDR_FIXED, low};
	endfunction

	function automatic logic [7:0] read_byte(input logic idx, input logic sel,
		input odp_chan_t c1, input odp_chan_t c2, input logic [1:0] st);
		logic [7:0] b;
		b = sel ? c2.code : c1.code;
		if (idx) begin
			b = {st, 6'h00};
		end
		return b;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Serial protocol engine

	odp_state_t state_q;
	logic [3:0] bit_cnt_q;
	logic [7:0] shift_q;
	logic       rw_q;
	logic       byte_idx_q;
	logic       first_q;
	logic       mack_q;
	logic       rx_done;
	logic [7:0] tx_first;
	logic [7:0] tx_next;

	// Byte complete in receive direction, handed to the command logic
	assign rx_done = fall_p && state_q == ST_RX && bit_cnt_q == 4'h8;

	// Bytes offered to the master at the start of a read and after each master ACK
	assign tx_first = read_byte(1'h0, chan_sel_q, chan1_o, chan2_o, status_w);
	assign tx_next  = read_byte(byte_idx_q, chan_sel_q, chan1_o, chan2_o, status_w);

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			state_q    <= ST_IDLE;
			bit_cnt_q  <= 4'h0;
			shift_q    <= 8'h00;
			rw_q       <= 1'h0;
			byte_idx_q <= 1'h0;
			first_q    <= 1'h1;
			mack_q     <= 1'h0;
			sda_oe_o   <= 1'h0;
			sda_o      <= 1'h0;
		end else if (ce_i) begin
			sda_o <= 1'h0;
			if (start_p) begin
				state_q   <= ST_ADDR;
				bit_cnt_q <= 4'h0;
				sda_oe_o  <= 1'h0;
			end else if (stop_p) begin
				state_q  <= ST_IDLE;
				sda_oe_o <= 1'h0;
			end else if (rise_p) begin
				if (state_q == ST_ADDR || state_q == ST_RX) begin
					shift_q   <= {shift_q[6:0], sda_s};
					bit_cnt_q <= bit_cnt_q + 4'h1;
				end else if (state_q == ST_TX_ACK) begin
					mack_q <= ~sda_s;
				end
			end else if (fall_p) begin
				case (state_q)
					ST_ADDR: begin
						if (bit_cnt_q == 4'h8) begin
							if (addr_match(shift_q[7:1], strap_s)) begin
								rw_q     <= shift_q[0];
								sda_oe_o <= 1'h1;
								state_q  <= ST_ADDR_ACK;
							end else begin
								state_q <= ST_IDLE;
							end
						end
					end
					ST_ADDR_ACK: begin
						bit_cnt_q <= 4'h0;
						if (rw_q) begin
							shift_q    <= tx_first;
							sda_oe_o   <= ~tx_first[7];
							byte_idx_q <= 1'h1;
							state_q    <= ST_TX;
						end else begin
							sda_oe_o <= 1'h0;
							first_q  <= 1'h1;
							state_q  <= ST_RX;
						end
					end
					ST_RX: begin
						if (bit_cnt_q == 4'h8) begin
							sda_oe_o <= 1'h1;
							state_q  <= ST_RX_ACK;
						end
					end
					ST_RX_ACK: begin
						sda_oe_o  <= 1'h0;
						bit_cnt_q <= 4'h0;
						first_q   <= 1'h0;
						state_q   <= ST_RX;
					end
					ST_TX: begin
						if (bit_cnt_q == 4'h7) begin
							sda_oe_o <= 1'h0;
							state_q  <= ST_TX_ACK;
						end else begin
							shift_q   <= {shift_q[6:0], 1'h0};
							sda_oe_o  <= ~shift_q[6];
							bit_cnt_q <= bit_cnt_q + 4'h1;
						end
					end
					ST_TX_ACK: begin
						// Further bytes alternate code and validation byte
						if (mack_q) begin
							shift_q    <= tx_next;
							sda_oe_o   <= ~tx_next[7];
							byte_idx_q <= ~byte_idx_q;
							bit_cnt_q  <= 4'h0;
							state_q    <= ST_TX;
						end else begin
							state_q <= ST_IDLE;
						end
					end
					default: begin
						state_q <= ST_IDLE;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Command decode

	logic       ow_q;
	logic       load_q;
	logic [7:0] held_q [2];
	logic       ins_ok;
	logic       ins_take;
	logic       data_take;
	logic       writable;

	// A set reserved bit voids the instruction; the byte is still acknowledged
	assign ins_ok    = ~shift_q[INS_ZERO_BIT];
	assign ins_take  = rx_done && first_q && ins_ok;
	assign data_take = rx_done && !first_q;
	// Blown fuses freeze the wiper unless the override is active
	assign writable  = status_w != STAT_DONE || ow_q;
	assign prog_req  = ins_take && shift_q[INS_PROG_BIT];
	// Burn target follows the instruction just received, not the one before it
	assign prog_chan = shift_q[INS_CHAN_BIT];
	assign prog_code = prog_chan ? chan2_o.code : chan1_o.code;

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			chan_sel_q <= 1'h0;
			ow_q       <= 1'h0;
		end else if (ce_i && ins_take) begin
			chan_sel_q <= shift_q[INS_CHAN_BIT];
			ow_q       <= shift_q[INS_OW_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Wiper latches

	odp_chan_t chan_q [2];

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			load_q <= 1'h1;
			for (int i = 0; i < 2; i++) begin
				chan_q[i] <= '{a_open: 1'h0, w_to_b: 1'h0, code: WIPER_MIDSCALE};
				held_q[i] <= WIPER_MIDSCALE;
			end
		end else if (ce_i) begin
			load_q <= 1'h0;
			for (int i = 0; i < 2; i++) begin
				if (load_q) begin
					chan_q[i].code <= fuse_blown_i ? fuse_code_i[i] : WIPER_MIDSCALE;
				end else if (ins_take) begin
					if (shift_q[INS_CHAN_BIT] == 1'(i)) begin
						// Only the switch state moves; the code is left alone
						chan_q[i].a_open <= shift_q[INS_SD_BIT];
						chan_q[i].w_to_b <= shift_q[INS_SD_BIT];
					end
					if (shift_q[INS_OW_BIT] && !ow_q) begin
						held_q[i] <= chan_q[i].code;
					end else if (!shift_q[INS_OW_BIT] && ow_q) begin
						chan_q[i].code <= held_q[i];
					end
				end else if (data_take && writable && chan_sel_q == 1'(i)) begin
					chan_q[i].code <= shift_q;
				end
			end
		end
	end

	assign chan1_o = chan_q[0];
	assign chan2_o = chan_q[1];

endmodule

`default_nettype wire

// File: verif/odp_cmd_slave_sva.sv
`timescale 1ns/1ps
`default_nettype none

module odp_chk
	import odp_pkg::*;
#(
	parameter bit STRAPPED = 1'b1,
	parameter int PROG_LEN = PROG_CYCLES
) (
	// Clock and reset
	input wire logic            sys_clk_i,
	input wire logic            sys_rst_i,
	// Watched ports
	input wire logic            sda_o,
	input wire logic            sda_oe_o,
	input wire logic            fuse_blown_i,
	input wire logic [1:0][7:0] fuse_code_i,
	input wire odp_burn_t       fuse_burn_o,
	input wire odp_chan_t       chan1_o,
	input wire odp_chan_t       chan2_o,
	input wire logic [1:0]      fuse_status_o
);
	// Burn length counted here, a repetition of PROG_LEN would be too long to unroll
	logic [31:0] burn_len_q;
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i || !fuse_burn_o.burn) begin
			burn_len_q <= '0;
		end else begin
			burn_len_q <= burn_len_q + 32'h1;
		end
	end

	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_boot;
		$fell(sys_rst_i) ##2 1'b1;
	endsequence
	sequence s_burn_end;
		fuse_burn_o.burn ##1 !fuse_burn_o.burn;
	endsequence

	property p_sd_ties;
		chan1_o.a_open == chan1_o.w_to_b && chan2_o.a_open == chan2_o.w_to_b;
	endproperty
	property p_sd_keeps;
		$changed(chan2_o.a_open) |-> $stable(chan2_o.code);
	endproperty
	property p_boot;
		s_boot |-> chan1_o.code == (fuse_blown_i ? fuse_code_i[0] : WIPER_MIDSCALE)
			&& chan2_o.code == (fuse_blown_i ? fuse_code_i[1] : WIPER_MIDSCALE)
			&& fuse_status_o == (fuse_blown_i ? STAT_DONE : STAT_READY);
	endproperty
	property p_burn_code;
		$rose(fuse_burn_o.burn) |-> fuse_burn_o.code == (fuse_burn_o.chan ? chan2_o.code : chan1_o.code);
	endproperty
	property p_burn_len;
		$fell(fuse_burn_o.burn) |-> burn_len_q == PROG_LEN;
	endproperty
	property p_burn_gate;
		$rose(fuse_burn_o.burn) |-> $past(fuse_status_o) == STAT_READY;
	endproperty
	property p_burn_result;
		s_burn_end |-> fuse_status_o inside {STAT_DONE, STAT_FATAL};
	endproperty
	property p_done_holds;
		fuse_status_o == STAT_DONE |=> fuse_status_o == STAT_DONE;
	endproperty
	property p_stat_cause;
		$changed(fuse_status_o) |-> $fell(fuse_burn_o.burn) || $past(sys_rst_i, 2) || $past(sys_rst_i, 3);
	endproperty
	property p_sda_low;
		sda_oe_o |-> !sda_o;
	endproperty

	a_sd_ties: assert property (p_sd_ties) else $error("shutdown outputs differ");
	a_sd_keeps: assert property (p_sd_keeps) else $error("code moved with shutdown");
	a_boot: assert property (p_boot) else $error("wrong preset after reset");
	a_burn_code: assert property (p_burn_code) else $error("burn code not current wiper");
	a_burn_len: assert property (p_burn_len) else $error("burn length wrong");
	a_burn_gate: assert property (p_burn_gate) else $error("burn while not ready");
	a_burn_result: assert property (p_burn_result) else $error("no status after burn");
	a_done_holds: assert property (p_done_holds) else $error("done status left");
	a_stat_cause: assert property (p_stat_cause) else $error("status changed without cause");
	a_sda_low: assert property (p_sda_low) else $error("data pin driven high");
endmodule

bind odp_cmd_slave odp_chk #(.STRAPPED(STRAPPED), .PROG_LEN(PROG_LEN)) i_odp_chk (
	.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
	.fuse_blown_i(fuse_blown_i), .fuse_code_i(fuse_code_i), .fuse_burn_o(fuse_burn_o),
	.chan1_o(chan1_o), .chan2_o(chan2_o), .fuse_status_o(fuse_status_o));

`default_nettype wire

// File: verif/odp_i2c_master.sv
`timescale 1ns/1ps
`default_nettype none

module odp_i2c_master #(
	parameter int Q = 8
) (
	// Clock
	input  wire logic sys_clk_i,
	// Bus lines
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_low_o
);
	// Clock line rests high between frames
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	task automatic hold(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask
	task automatic start();
		sda_low_o = 1'b0;
		scl_o = 1'b1;
		hold(Q);
		sda_low_o = 1'b1;
		hold(Q);
	endtask
	// Data changes only mid-low, so the slave never sees a false start or stop
	task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			scl_o = 1'b0;
			hold(Q);
			sda_low_o = !tx[i];
			hold(Q);
			scl_o = 1'b1;
			hold(Q);
			rx[i] = sda_i;
		end
	endtask
	task automatic stop();
		scl_o = 1'b0;
		hold(Q);
		sda_low_o = 1'b1;
		hold(Q);
		scl_o = 1'b1;
		hold(Q);
		sda_low_o = 1'b0;
		hold(Q);
	endtask
endmodule

`default_nettype wire

// File: verif/odp_cmd_slave_tb.sv
`timescale 1ns/1ps
`default_nettype none

module odp_cmd_slave_tb;
	import odp_pkg::*;
	localparam int PL = 200;
	localparam logic [7:0] ADR_W = 8'h5C;
	logic            sys_clk_i = 1'b0;
	logic            sys_rst_i = 1'b1;
	logic            scl, m_low, sda, sda_oe, sda_out;
	logic            blown = 1'b0;
	logic            ok = 1'b1;
	logic [1:0][7:0] fcode = '0;
	logic [8:0]      rx;
	logic [7:0]      rb [2];
	logic [1:0]      st;
	odp_burn_t       burn;
	odp_chan_t       c1, c2;
	int              failures = 0;
	int              n_compared = 0;

	always #12.5 sys_clk_i = !sys_clk_i;
	// Open-drain data line with pull-up
	assign sda = !(m_low || (sda_oe && !sda_out));

	odp_cmd_slave #(.STRAPPED(1'b1), .PROG_LEN(PL)) i_odp_cmd_slave (
		.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_out), .sda_oe_o(sda_oe), .strap_pin_hi_i(1'b1), .strap_pin_lo_i(1'b0),
		.fuse_blown_i(blown), .fuse_code_i(fcode), .fuse_ok_i(ok), .fuse_burn_o(burn),
		.chan1_o(c1), .chan2_o(c2), .fuse_status_o(st));
	odp_i2c_master i_odp_i2c_master (.sys_clk_i(sys_clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low));

	////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic results();
		$display("failures %0d compared %0d", failures, n_compared);
		if (failures == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask
	task automatic rst(input logic b);
		blown = b;
		sys_rst_i = 1'b1;
		cyc(12);
		sys_rst_i = 1'b0;
		cyc(4);
	endtask
	task automatic wr(input logic [7:0] ins, input logic [7:0] d0, input logic [7:0] d1, input int nd);
		i_odp_i2c_master.start();
		i_odp_i2c_master.xfer({ADR_W, 1'b1}, rx);
		chk("addr_ack", rx[0], 1'b0);
		i_odp_i2c_master.xfer({ins, 1'b1}, rx);
		chk("ins_ack", rx[0], 1'b0);
		for (int i = 0; i < nd; i++) begin
			i_odp_i2c_master.xfer({(i > 0) ? d1 : d0, 1'b1}, rx);
			chk("data_ack", rx[0], 1'b0);
		end
		i_odp_i2c_master.stop();
		cyc(4);
	endtask
	task automatic rd();
		i_odp_i2c_master.start();
		i_odp_i2c_master.xfer({ADR_W | 8'h01, 1'b1}, rx);
		chk("rd_ack", rx[0], 1'b0);
		i_odp_i2c_master.xfer(9'h1FE, rx);
		rb[0] = rx[8:1];
		i_odp_i2c_master.xfer(9'h1FF, rx);
		rb[1] = rx[8:1];
		i_odp_i2c_master.stop();
	endtask
	// Nothing else is sent while the fuses burn
	task automatic burn_end();
		int n;
		n = 0;
		while (burn.burn === 1'b1 && n < 1000) begin
			cyc(1);
			n++;
		end
		if (n >= 1000) begin
			failures++;
			results();
		end
		cyc(2);
	endtask

	initial begin
		rst(1'b0);
		chk("c1", c1, {2'b00, WIPER_MIDSCALE});
		chk("c2", c2, {2'b00, WIPER_MIDSCALE});
		chk("st", st, STAT_READY);
		wr(8'h00, 8'h5A, 8'hC3, 2);
		chk("c1", c1, 10'h0C3);
		chk("c2", c2, 10'h080);
		wr(8'h80, 8'h3C, 8'h00, 1);
		wr(8'h50, 8'h00, 8'h00, 0);
		chk("c1", c1, 10'h0C3);
		rd();
		chk("rd_code", rb[0], 8'h3C);
		chk("rd_stat", rb[1][7:6], STAT_READY);
		wr(8'hC0, 8'h00, 8'h00, 0);
		chk("c2_sd", c2, 10'h33C);
		wr(8'h80, 8'h00, 8'h00, 0);
		chk("c2_run", c2, 10'h03C);
		i_odp_i2c_master.start();
		i_odp_i2c_master.xfer(9'h0BD, rx);
		i_odp_i2c_master.stop();
		chk("nack", rx[0], 1'b1);
		wr(8'h20, 8'h00, 8'h00, 0);
		chk("burn", burn, {1'b1, 1'b0, 8'hC3});
		burn_end();
		chk("st", st, STAT_DONE);
		wr(8'h00, 8'h77, 8'h00, 1);
		chk("c1", c1, 10'h0C3);
		wr(8'h08, 8'h44, 8'h00, 1);
		chk("c1_ow", c1, 10'h044);
		wr(8'h07, 8'h00, 8'h00, 0);
		chk("c1_back", c1, 10'h0C3);
		rd();
		chk("rd_code", rb[0], 8'hC3);
		chk("rd_stat", rb[1][7:6], STAT_DONE);
		wr(8'h20, 8'h00, 8'h00, 0);
		chk("reburn", burn.burn, 1'b0);
		fcode = {8'h21, 8'h9E};
		rst(1'b1);
		chk("c1", c1, 10'h09E);
		chk("c2", c2, 10'h021);
		chk("st", st, STAT_DONE);
		ok = 1'b0;
		rst(1'b0);
		wr(8'h80, 8'h55, 8'h00, 1);
		wr(8'hA0, 8'h00, 8'h00, 0);
		chk("burn", burn, {1'b1, 1'b1, 8'h55});
		burn_end();
		chk("st", st, STAT_FATAL);
		rd();
		chk("rd_code", rb[0], 8'h55);
		chk("rd_stat", rb[1][7:6], STAT_FATAL);
		// A failed unit is rejected, so no further program command goes out
		results();
	end
endmodule

`default_nettype wire
